// ===== logic/ebi_mux_cfg.svh
// constants of the external bus pin multiplexer
`ifndef EBI_MUX_CFG_SVH
`define EBI_MUX_CFG_SVH
// ----------------------------------------------------------------
// bus geometry
// ----------------------------------------------------------------
`define EBI_ADDR_W 26
`define EBI_DATA_W 32
`define EBI_CS_N 6
`define EBI_DRAM_ADDR_W 14
// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define EBI_DRAM_A10_BIT 10
`define EBI_SHARED_DATA_LO 24
`define EBI_SHARED_A20 20
`define EBI_SHARED_CS2 2
`define EBI_SHARED_CS4 4
`define EBI_SHARED_CS5 5
`define EBI_NAND_CS 3
`define EBI_DRAM_CS 1
// ----------------------------------------------------------------
// reset and idle values
// ----------------------------------------------------------------
`define EBI_CS_IDLE 6'h3F
`define EBI_ADDR_RST 26'h0000000
`define EBI_ADDR_OE_OFF 26'h3FFFFFF
`define EBI_DATA_RST 32'h00000000
`define EBI_DATA_OE_OFF 32'hFFFFFFFF
`endif

// ===== logic/ebi_mux_pkg.sv
// types shared by the external bus pin multiplexer files
package ebi_mux_pkg;
`include "ebi_mux_cfg.svh"
	// static device wiring, chosen by the board
	typedef enum logic [2:0] {
		W8 = 3'h0, W2X8 = 3'h1, W16 = 3'h2,
		W4X8 = 3'h3, W2X16 = 3'h4, W32 = 3'h5
	} width_mode_t;
	// which controller owns the pins
	typedef enum logic [2:0] {
		OWN_IDLE = 3'h1, OWN_STATIC = 3'h2, OWN_DRAM = 3'h4
	} own_state_t;
	// static controller request, all active high
	typedef struct packed {
		logic [`EBI_CS_N-1:0] cs;
		logic rd;
		logic wr;
		logic [3:0] be;
		logic [`EBI_ADDR_W-1:0] addr;
		logic [`EBI_DATA_W-1:0] wdata;
		logic wdata_oe;
	} static_req_t;
	// dynamic controller request; strobes active high, dqm as pin level
	typedef struct packed {
		logic cs;
		logic ras;
		logic cas;
		logic we;
		logic cke;
		logic [2:0] ba;
		logic [3:0] dqm;
		logic [`EBI_DRAM_ADDR_W-1:0] addr;
		logic [`EBI_DATA_W-1:0] wdata;
		logic wdata_oe;
	} dram_req_t;
	// configuration and pin assignment bits
	typedef struct packed {
		logic cs1_to_dram;
		logic cs3_nand_en;
		logic hi_data;
		logic a20;
		logic a23_25;
		logic cs2;
		logic cs4;
		logic cs5;
	} mux_cfg_t;
	// byte strobes for a static access, pin levels
	typedef struct packed {
		logic a0;
		logic a1;
		logic wr0;
		logic pin1;
		logic pin3;
	} strobe_t;
	// every pin the multiplexer drives; oe_n low means driven
	typedef struct packed {
		logic [`EBI_ADDR_W-1:0] addr;
		logic [`EBI_ADDR_W-1:0] addr_oe_n;
		logic [`EBI_DATA_W-1:0] data_out;
		logic [`EBI_DATA_W-1:0] data_oe_n;
		logic [`EBI_CS_N-1:0] static_chip_selects;
		logic [`EBI_CS_N-1:0] cs_oe_n;
		logic read_strobe_low;
		logic write_strobe_low;
		logic byte_pin1_low;
		logic byte_pin3_low;
		logic flash_chip_select;
		logic flash_output_strobe;
		logic flash_write_strobe;
		logic dram_clock_gate;
		logic [2:0] dram_bank_select;
		logic dram_write_strobe;
		logic dram_row_strobe_low;
		logic dram_col_strobe_low;
		logic dram_addr_ten_pin;
		logic [1:0] dram_dqm;
	} ebi_pins_t;
endpackage

// ===== logic/strobe_map.sv
// byte write and byte select mapping for static devices
`timescale 1ns/1ps
module strobe_map
	import ebi_mux_pkg::*;
(
	input wire width_mode_t mode,
	input wire logic active,
	input wire logic wr,
	input wire logic [3:0] be,
	input wire logic [1:0] addr_lo,
	output strobe_t strb
);
	// ----------------------------------------------------------------
	// lane decode
	// ----------------------------------------------------------------
	// strobes drop only inside an access; write lanes gated by write, select lanes by access only
	always_comb begin
		logic [3:0] wl;
		logic [3:0] bl;
		wl = {4{active & wr}} & be;
		bl = {4{active}} & be;
		strb.a0 = addr_lo[0];
		strb.a1 = addr_lo[1];
		strb.wr0 = ~(active & wr);
		strb.pin1 = 1'b1;
		strb.pin3 = 1'b1;
		case (mode)
			W8: begin
				// both low pins are plain address
			end
			W2X8: begin
				strb.wr0 = ~wl[0];
				strb.pin1 = ~wl[1];
			end
			W16: begin
				strb.a0 = ~bl[0];
				strb.pin1 = ~bl[1];
			end
			W4X8: begin
				strb.wr0 = ~wl[0];
				strb.pin1 = ~wl[1];
				strb.a1 = ~wl[2];
				strb.pin3 = ~wl[3];
			end
			W2X16, W32: begin
				strb.a0 = ~bl[0];
				strb.pin1 = ~bl[1];
				strb.a1 = ~bl[2];
				strb.pin3 = ~bl[3];
			end
			default: begin
				// unknown wiring: address only, single write strobe
			end
		endcase
	end
endmodule // strobe_map

// ===== logic/ebi_pin_mux.sv
// pin multiplexer sharing the external bus between memory controllers
`timescale 1ns/1ps
`include "ebi_mux_cfg.svh"
module ebi_pin_mux
	import ebi_mux_pkg::*;
#(
	parameter int SHARED_DATA_LO = `EBI_SHARED_DATA_LO
)(
	input wire logic core_clk,
	input wire logic rst,
	input wire logic static_own,
	input wire logic dram_own,
	input wire static_req_t static_req,
	input wire dram_req_t dram_req,
	input wire width_mode_t width_mode,
	input wire mux_cfg_t cfg,
	input wire logic [`EBI_DATA_W-1:0] data_in,
	input wire logic external_wait_low,
	output ebi_pins_t pins,
	output logic [`EBI_DATA_W-1:0] rdata,
	output logic wait_low_sync
);
	// ----------------------------------------------------------------
	// parameter check
	// ----------------------------------------------------------------
	if (SHARED_DATA_LO < 1 || SHARED_DATA_LO > `EBI_DATA_W) begin : g_chk
		$error("shared data boundary out of range");
	end
	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		own_state_t own;
		ebi_pins_t pins;
		logic wait_s1; // first sync stage, read only by wait_s2
		logic wait_s2;
		logic [`EBI_DATA_W-1:0] rd_s1; // first sync stage
		logic [`EBI_DATA_W-1:0] rd_s2;
	} st_t;
	st_t st_q; // registered state
	st_t st_d; // next state
	strobe_t strb; // static byte strobes
	// static access in progress on any select
	wire logic static_active = |static_req.cs;
	// byte strobe decode kept apart so the width modes sit in one place
	strobe_map u_strobe_map (.mode(width_mode), .active(static_active),
		.wr(static_req.wr), .be(static_req.be),
		.addr_lo(static_req.addr[1:0]), .strb(strb));
	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	// one register stage between any controller and the pads
	always_comb begin
		st_d = st_q;
		// pin inputs pass two flops before use
		st_d.wait_s1 = external_wait_low;
		st_d.wait_s2 = st_q.wait_s1;
		st_d.rd_s1 = data_in;
		st_d.rd_s2 = st_q.rd_s1;
		// static wins a tie; the arbiter should never grant both
		if (static_own) begin
			st_d.own = OWN_STATIC;
		end else if (dram_own) begin
			st_d.own = OWN_DRAM;
		end else begin
			st_d.own = OWN_IDLE;
		end
		// idle defaults: selects and strobes inactive high, data released, address held
		st_d.pins.static_chip_selects = `EBI_CS_IDLE;
		st_d.pins.read_strobe_low = 1'b1;
		st_d.pins.write_strobe_low = 1'b1;
		st_d.pins.byte_pin1_low = 1'b1;
		st_d.pins.byte_pin3_low = 1'b1;
		st_d.pins.flash_chip_select = 1'b1;
		st_d.pins.flash_output_strobe = 1'b1;
		st_d.pins.flash_write_strobe = 1'b1;
		st_d.pins.dram_write_strobe = 1'b1;
		st_d.pins.dram_row_strobe_low = 1'b1;
		st_d.pins.dram_col_strobe_low = 1'b1;
		st_d.pins.data_oe_n = `EBI_DATA_OE_OFF;
		// clock gate belongs to the dynamic controller at all times
		st_d.pins.dram_clock_gate = dram_req.cke;
		case (st_d.own)
			OWN_STATIC: begin
				st_d.pins.addr[`EBI_ADDR_W-1:2] =
					static_req.addr[`EBI_ADDR_W-1:2];
				// low address pins double as byte strobes
				st_d.pins.addr[0] = strb.a0;
				st_d.pins.addr[1] = strb.a1;
				st_d.pins.write_strobe_low = strb.wr0;
				st_d.pins.byte_pin1_low = strb.pin1;
				st_d.pins.byte_pin3_low = strb.pin3;
				st_d.pins.read_strobe_low = ~static_req.rd;
				st_d.pins.static_chip_selects = ~static_req.cs;
				// select one lent to the dynamic side is kept off
				if (cfg.cs1_to_dram) begin
					st_d.pins.static_chip_selects[`EBI_DRAM_CS] = 1'b1;
				end
				// flash strobes only on the flash-enabled select
				if (cfg.cs3_nand_en && static_req.cs[`EBI_NAND_CS]) begin
					st_d.pins.flash_chip_select = 1'b0;
					st_d.pins.flash_output_strobe = ~static_req.rd;
					st_d.pins.flash_write_strobe = ~static_req.wr;
				end
				if (static_req.wdata_oe) begin
					st_d.pins.data_out = static_req.wdata;
					st_d.pins.data_oe_n = '0;
				end
			end
			OWN_DRAM: begin
				st_d.pins.addr[11:2] = dram_req.addr[9:0];
				st_d.pins.addr[15:13] = dram_req.addr[13:11];
				st_d.pins.dram_addr_ten_pin =
					dram_req.addr[`EBI_DRAM_A10_BIT];
				st_d.pins.dram_bank_select = dram_req.ba;
				st_d.pins.dram_row_strobe_low = ~dram_req.ras;
				st_d.pins.dram_col_strobe_low = ~dram_req.cas;
				st_d.pins.dram_write_strobe = ~dram_req.we;
				st_d.pins.dram_dqm = dram_req.dqm[1:0];
				st_d.pins.byte_pin1_low = dram_req.dqm[1];
				st_d.pins.addr[1] = dram_req.dqm[2];
				st_d.pins.byte_pin3_low = dram_req.dqm[3];
				if (cfg.cs1_to_dram) begin
					st_d.pins.static_chip_selects[`EBI_DRAM_CS] =
						~dram_req.cs;
				end
				if (dram_req.wdata_oe) begin
					st_d.pins.data_out = dram_req.wdata;
					st_d.pins.data_oe_n = '0;
				end
			end
			default: begin // idle: defaults above stand
			end
		endcase
		// port-shared pins released unless handed to the bus
		st_d.pins.addr_oe_n = '0;
		st_d.pins.cs_oe_n = '0;
		if (!cfg.hi_data) begin
			for (int i = SHARED_DATA_LO; i < `EBI_DATA_W; i++) begin
				st_d.pins.data_oe_n[i] = 1'b1;
			end
		end
		st_d.pins.addr_oe_n[`EBI_SHARED_A20] = ~cfg.a20;
		st_d.pins.addr_oe_n[25:23] = {3{~cfg.a23_25}};
		st_d.pins.cs_oe_n[`EBI_SHARED_CS2] = ~cfg.cs2;
		st_d.pins.cs_oe_n[`EBI_SHARED_CS4] = ~cfg.cs4;
		st_d.pins.cs_oe_n[`EBI_SHARED_CS5] = ~cfg.cs5;
	end
	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			st_q <= '0;
			st_q.own <= OWN_IDLE;
			st_q.pins.addr <= `EBI_ADDR_RST;
			st_q.pins.addr_oe_n <= `EBI_ADDR_OE_OFF;
			st_q.pins.data_out <= `EBI_DATA_RST;
			st_q.pins.data_oe_n <= `EBI_DATA_OE_OFF;
			st_q.pins.static_chip_selects <= `EBI_CS_IDLE;
			st_q.pins.cs_oe_n <= `EBI_CS_IDLE;
			{st_q.pins.read_strobe_low, st_q.pins.write_strobe_low,
				st_q.pins.byte_pin1_low, st_q.pins.byte_pin3_low,
				st_q.pins.flash_chip_select, st_q.pins.flash_output_strobe,
				st_q.pins.flash_write_strobe, st_q.pins.dram_write_strobe,
				st_q.pins.dram_row_strobe_low,
				st_q.pins.dram_col_strobe_low} <= 10'h3FF;
			{st_q.wait_s1, st_q.wait_s2} <= 2'h3;
		end else begin
			st_q <= st_d;
		end
	end
	// outputs straight from flops
	assign pins = st_q.pins;
	assign rdata = st_q.rd_s2;
	assign wait_low_sync = st_q.wait_s2;
	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	property p_flash_strobes;
		@(posedge core_clk) disable iff (rst)
		(static_own && cfg.cs3_nand_en && static_req.cs[3] && static_req.rd)
		|=> (!pins.flash_chip_select && !pins.flash_output_strobe);
	endproperty
	a_flash_strobes: assert property (p_flash_strobes)
		else $error("flash strobes not low on flash read");
	property p_flash_off;
		@(posedge core_clk) disable iff (rst)
		!cfg.cs3_nand_en |=> (pins.flash_chip_select &&
			pins.flash_output_strobe && pins.flash_write_strobe);
	endproperty
	a_flash_off: assert property (p_flash_off)
		else $error("flash strobe active while flash disabled");
	property p_dram_cs;
		@(posedge core_clk) disable iff (rst)
		(!static_own && dram_own && cfg.cs1_to_dram && dram_req.cs)
		|=> !pins.static_chip_selects[1];
	endproperty
	a_dram_cs: assert property (p_dram_cs)
		else $error("dynamic chip select not low");
	property p_cs1_static_blocked;
		@(posedge core_clk) disable iff (rst)
		(static_own && cfg.cs1_to_dram) |=> pins.static_chip_selects[1];
	endproperty
	a_cs1_static_blocked: assert property (p_cs1_static_blocked)
		else $error("static side drove lent chip select one");
	property p_ras_cas;
		@(posedge core_clk) disable iff (rst)
		(!static_own && dram_own) |=>
		(pins.dram_row_strobe_low == !$past(dram_req.ras) &&
		 pins.dram_col_strobe_low == !$past(dram_req.cas));
	endproperty
	a_ras_cas: assert property (p_ras_cas)
		else $error("row or column strobe polarity wrong");
	property p_a10_hold;
		@(posedge core_clk) disable iff (rst)
		!(dram_own && !static_own) |=> $stable(pins.dram_addr_ten_pin);
	endproperty
	a_a10_hold: assert property (p_a10_hold)
		else $error("address-ten pin moved without dynamic owner");
	property p_dram_addr;
		@(posedge core_clk) disable iff (rst)
		(!static_own && dram_own) |=>
		(pins.addr[11:2] == $past(dram_req.addr[9:0]) &&
		 pins.addr[15:13] == $past(dram_req.addr[13:11]));
	endproperty
	a_dram_addr: assert property (p_dram_addr)
		else $error("dynamic address not routed");
	property p_static_addr;
		@(posedge core_clk) disable iff (rst)
		static_own |=> pins.addr[25:2] == $past(static_req.addr[25:2]);
	endproperty
	a_static_addr: assert property (p_static_addr)
		else $error("static address not routed");
	property p_two_byte;
		@(posedge core_clk) disable iff (rst)
		(static_own && width_mode == W2X8 && static_req.wr &&
		 static_req.cs[0] && static_req.be[1:0] == 2'h2)
		|=> (!pins.byte_pin1_low && pins.write_strobe_low);
	endproperty
	a_two_byte: assert property (p_two_byte)
		else $error("upper byte write strobe wrong");
	property p_four_byte;
		@(posedge core_clk) disable iff (rst)
		(static_own && width_mode == W4X8 && static_req.wr &&
		 static_req.cs[0]) |=>
		({pins.byte_pin3_low, pins.addr[1], pins.byte_pin1_low,
		  pins.write_strobe_low} == ~$past(static_req.be));
	endproperty
	a_four_byte: assert property (p_four_byte)
		else $error("byte lane write strobes wrong");
	property p_half_sel;
		@(posedge core_clk) disable iff (rst)
		(static_own && width_mode == W2X16 && static_req.cs[0]) |=>
		(pins.addr[0] == !$past(static_req.be[0]) &&
		 pins.byte_pin1_low == !$past(static_req.be[1]) &&
		 pins.addr[1] == !$past(static_req.be[2]) &&
		 pins.byte_pin3_low == !$past(static_req.be[3]));
	endproperty
	a_half_sel: assert property (p_half_sel)
		else $error("byte selects wrong for half-word devices");
	property p_shared_release;
		@(posedge core_clk) disable iff (rst)
		(!cfg.hi_data && !cfg.cs5) |=>
		(&pins.data_oe_n[31:24] && pins.cs_oe_n[5]);
	endproperty
	a_shared_release: assert property (p_shared_release)
		else $error("unassigned shared pin driven");
	property p_idle;
		@(posedge core_clk) disable iff (rst)
		(!static_own && !dram_own) |=> (&pins.static_chip_selects &&
		 pins.read_strobe_low && pins.write_strobe_low &&
		 $stable(pins.addr));
	endproperty
	a_idle: assert property (p_idle)
		else $error("idle bus not quiet");
	property p_wait_sync;
		@(posedge core_clk) disable iff (rst)
		!external_wait_low [*3] |-> !wait_low_sync;
	endproperty
	a_wait_sync: assert property (p_wait_sync)
		else $error("wait not passed after two stages");
endmodule // ebi_pin_mux

// ===== testbench/ext_mem_model.sv
// behavioural model of the memories on the far side of the bus
`timescale 1ns/1ps
module ext_mem_model
	import ebi_mux_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst,
	input wire ebi_pins_t pins,
	input wire logic [31:0] rd_val,
	input wire logic stall,
	output logic [31:0] data_in,
	output logic external_wait_low
);
	// ----------------------------------------------------------------
	// released bus pattern
	// ----------------------------------------------------------------
	logic [31:0] float_q; // flips each cycle, so no stale value survives
	logic dev_rd; // some static device is being read
	// free-running pattern for undriven data lines
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			float_q <= 32'h5A5A5A5A;
		end else begin
			float_q <= ~float_q;
		end
	end
	// ----------------------------------------------------------------
	// wire level of the data pins
	// ----------------------------------------------------------------
	// the board wiring by width is folded into rd_val
	always_comb begin
		dev_rd = !pins.read_strobe_low && !(&pins.static_chip_selects);
		for (int i = 0; i < 32; i++) begin
			if (!pins.data_oe_n[i]) begin
				data_in[i] = pins.data_out[i]; // the multiplexer drives the line
			end else if (dev_rd) begin
				data_in[i] = rd_val[i]; // memory answers the read
			end else begin
				data_in[i] = float_q[i]; // nobody drives it
			end
		end
	end
	// wait pin is pulled up; pulled low only during a static read
	assign external_wait_low = !(stall && dev_rd);
endmodule // ext_mem_model

// ===== testbench/external_bus_pin_multiplexer_tb_top.sv
// self-checking bench of the external bus pin multiplexer
`timescale 1ns/1ps
module external_bus_pin_multiplexer_tb_top;
	import ebi_mux_pkg::*;
	// ----------------------------------------------------------------
	// signals
	// ----------------------------------------------------------------
	logic core_clk, rst, static_own, dram_own, stall;
	static_req_t static_req;
	dram_req_t dram_req;
	width_mode_t width_mode;
	mux_cfg_t cfg;
	wire logic [31:0] data_in;
	wire logic external_wait_low;
	ebi_pins_t pins;
	logic [31:0] rdata, rd_val;
	logic wait_low_sync;
	// reference state, snapshots taken where inputs are settled
	logic s_sown, s_down;
	static_req_t s_sr;
	dram_req_t s_dr;
	width_mode_t s_wm;
	mux_cfg_t s_cfg;
	logic [25:0] exp_addr; // address lines hold between accesses
	logic exp_a10;
	logic [31:0] d_hist [2];
	logic w_hist [2];
	int valid, err_count, total_checks;
	// ----------------------------------------------------------------
	// design and far side
	// ----------------------------------------------------------------
	ebi_pin_mux i_dut (.core_clk(core_clk), .rst(rst),
		.static_own(static_own), .dram_own(dram_own),
		.static_req(static_req), .dram_req(dram_req),
		.width_mode(width_mode), .cfg(cfg), .data_in(data_in),
		.external_wait_low(external_wait_low), .pins(pins),
		.rdata(rdata), .wait_low_sync(wait_low_sync));
	ext_mem_model i_mem (.core_clk(core_clk), .rst(rst), .pins(pins),
		.rd_val(rd_val), .stall(stall), .data_in(data_in),
		.external_wait_low(external_wait_low));
	// ----------------------------------------------------------------
	// compare and verdict
	// ----------------------------------------------------------------
	task automatic chk(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic close_out();
		$display("checks %0d errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// ----------------------------------------------------------------
	// reference model of one registered cycle
	// ----------------------------------------------------------------
	task automatic check_pins();
		logic [4:0] es, m; // {a0, a1, wr0, pin1, pin3} and mask
		logic [5:0] ecs, ecoe;
		logic [25:0] eaoe;
		logic [31:0] eoe, wd;
		logic [2:0] efl;
		logic any, rd, wr;
		logic [3:0] b;
		ecs = 6'h3F;
		es = 5'h1F;
		m = 5'h07;
		efl = 3'h7;
		rd = 1'b0;
		eoe = 32'hFFFFFFFF;
		wd = 32'h00000000;
		if (s_sown) begin
			ecs = ~s_sr.cs;
			if (s_cfg.cs1_to_dram) ecs[1] = 1'b1;
			any = !(&ecs);
			wr = s_sr.wr && any;
			rd = s_sr.rd && any;
			b = any ? s_sr.be : 4'h0;
			exp_addr[25:2] = s_sr.addr[25:2];
			wd = s_sr.wdata;
			if (s_sr.wdata_oe) eoe = 32'h00000000;
			// nand strobes only on select three when enabled
			if (s_cfg.cs3_nand_en && s_sr.cs[3]) begin
				efl = {1'b0, !rd, !wr};
			end
			// low pins not used as strobes carry the plain address
			m = 5'h1F;
			case (s_wm)
				W8: begin
					es = {s_sr.addr[0], s_sr.addr[1], !wr, 2'h3};
				end
				W2X8: begin
					es = {s_sr.addr[0], s_sr.addr[1], !(wr && b[0]),
						!(wr && b[1]), 1'b1};
				end
				W16: begin
					es = {!b[0], s_sr.addr[1], !wr, !b[1], 1'b1};
				end
				W4X8: begin
					es = {s_sr.addr[0], !(wr && b[2]), !(wr && b[0]),
						!(wr && b[1]), !(wr && b[3])};
				end
				default: begin
					es = {!b[0], !b[2], !wr, !b[1], !b[3]};
				end
			endcase
		end else if (s_down) begin
			// only select one can reach the dynamic controller
			ecs[1] = s_cfg.cs1_to_dram ? !s_dr.cs : 1'b1;
			exp_addr[11:2] = s_dr.addr[9:0];
			exp_addr[15:13] = s_dr.addr[13:11];
			exp_a10 = s_dr.addr[10];
			wd = s_dr.wdata;
			if (s_dr.wdata_oe) eoe = 32'h00000000;
			// byte masks ride on the shared strobe pins
			m = 5'h0F;
			es = {1'b1, s_dr.dqm[2], 1'b1, s_dr.dqm[1], s_dr.dqm[3]};
			chk("dqm", pins.dram_dqm, s_dr.dqm[1:0]);
			chk("bank", pins.dram_bank_select, s_dr.ba);
			if (s_dr.cs && s_cfg.cs1_to_dram) begin
				chk("ras_cas_we", {pins.dram_row_strobe_low,
					pins.dram_col_strobe_low, pins.dram_write_strobe},
					{!s_dr.ras, !s_dr.cas, !s_dr.we});
			end
		end
		// upper data lanes belong to the port unless assigned
		if (!s_cfg.hi_data) eoe[31:24] = 8'hFF;
		eaoe = 26'h0000000;
		eaoe[20] = !s_cfg.a20;
		eaoe[25:23] = {3{!s_cfg.a23_25}};
		ecoe = {!s_cfg.cs5, !s_cfg.cs4, 1'b0, !s_cfg.cs2, 2'h0};
		chk("selects", pins.static_chip_selects, ecs);
		chk("addr", pins.addr[25:2], exp_addr[25:2]);
		chk("a10", pins.dram_addr_ten_pin, exp_a10);
		chk("strobes", m & {pins.addr[0], pins.addr[1],
			pins.write_strobe_low, pins.byte_pin1_low,
			pins.byte_pin3_low}, m & es);
		chk("rd_strobe", pins.read_strobe_low, !rd);
		chk("flash", {pins.flash_chip_select, pins.flash_output_strobe,
			pins.flash_write_strobe}, efl);
		chk("data_oe", pins.data_oe_n, eoe);
		chk("data_out", pins.data_out | eoe, wd | eoe);
		chk("addr_oe", pins.addr_oe_n, eaoe);
		chk("cs_oe", pins.cs_oe_n, ecoe);
		chk("cke", pins.dram_clock_gate, s_dr.cke);
	endtask
	// ----------------------------------------------------------------
	// checker at the falling edge, where everything is settled
	// ----------------------------------------------------------------
	always @(negedge core_clk) begin
		if (rst) begin
			valid = 0;
			exp_addr = 26'h0000000;
			exp_a10 = 1'b0;
			chk("rst_cs", pins.static_chip_selects, 6'h3F);
			chk("rst_aoe", pins.addr_oe_n, 26'h3FFFFFF);
			chk("rst_wait", wait_low_sync, 1'b1);
		end else begin
			if (valid >= 1) check_pins();
			if (valid >= 2) begin
				chk("rdata", rdata, d_hist[1]);
				chk("wait", wait_low_sync, w_hist[1]);
			end
			d_hist[1] = d_hist[0];
			d_hist[0] = data_in;
			w_hist[1] = w_hist[0];
			w_hist[0] = external_wait_low;
			{s_sown, s_down} = {static_own, dram_own && !static_own};
			{s_sr, s_dr, s_wm, s_cfg} = {static_req, dram_req, width_mode, cfg};
			valid++;
		end
	end
	// ----------------------------------------------------------------
	// random stimulus, one new request every cycle
	// ----------------------------------------------------------------
	task automatic drive_rand();
		static_req_t sr;
		dram_req_t dr;
		mux_cfg_t c;
		int k, o;
		sr = static_req_t'({$urandom, $urandom, $urandom});
		dr = dram_req_t'({$urandom, $urandom});
		c = mux_cfg_t'($urandom);
		k = $urandom % 6;
		o = $urandom % 3;
		sr.cs = 6'h01 << k;
		sr.rd = (o == 1);
		sr.wr = (o == 2);
		// select one given away: request must be ignored
		if (k == 1 && c.cs1_to_dram) begin
			sr.rd = 1'b0;
			sr.wr = 1'b0;
			sr.be = 4'h0;
		end
		static_req <= sr;
		dram_req <= dr;
		cfg <= c;
		width_mode <= width_mode_t'($urandom % 6);
		static_own <= ($urandom % 3) == 0;
		dram_own <= ($urandom % 2) == 1;
		rd_val <= $urandom;
		stall <= ($urandom % 2) == 1;
	endtask
	// ----------------------------------------------------------------
	// clock, main sequence, watchdog
	// ----------------------------------------------------------------
	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end
	initial begin
		{rst, static_own, dram_own, stall} = 4'h8;
		{static_req, dram_req, cfg, rd_val} = '0;
		width_mode = W8;
		err_count = 0;
		total_checks = 0;
		void'($urandom(33));
		repeat (2) @(posedge core_clk);
		rst <= 1'b0;
		repeat (1500) begin
			@(posedge core_clk);
			drive_rand();
		end
		// a second reset in mid-traffic; the controllers fall quiet with
		// it, since owners, requests and configuration are cleared along with it
		@(posedge core_clk);
		rst <= 1'b1;
		{static_own, dram_own} <= 2'h0;
		static_req <= '0;
		dram_req <= '0;
		cfg <= '0;
		repeat (2) @(posedge core_clk);
		rst <= 1'b0;
		repeat (1500) begin
			@(posedge core_clk);
			drive_rand();
		end
		repeat (3) @(posedge core_clk);
		close_out();
	end
	// cuts a hang short at twice the expected run time
	initial begin
		#30000;
		err_count++;
		close_out();
	end
endmodule // external_bus_pin_multiplexer_tb_top
